// [rtl/debug_trigger_cfg.svh]
// Purpose: Constants for the debug trigger and debug control register bank
// Assumes: Registers reached by CSR address over the core's CSR port
// Notes:   Operation
// Operation
// - Type 6 reads back as the address-match layout, type code in bits 31:28.
// - Bit 27 reads 1; trigger data writes accepted only in debug mode.
// - Address compare only, break before; select, timing, hit, chain, vs, vu read 0.
// - Size field reads 0; accesses of any width match.
// - Action field holds 1; a match requests debug entry.
// - Compare mode keeps 0, 2 or 3; any other write stores 0.
// - Bit 6 enables machine-mode matching; bits 5, 4, 3 read 0.
// - Bits 2, 1, 0 enable fetch, store and load address matching.
// - Writing zero disables the trigger; reads back the fixed disabled value.
// - Disabled view: type 15, mode bit 1, bits 26:0 zero.
// - Compare register holds the full 32-bit address for matching.
// - Compare register writable per the mode bit of the first data register.
// - Exception view bits 24, 3, 2, 1 writable; unlisted bits read 0.
// - Exception view bits 11, 7, 5 writable selects.
// - Third data register and trigger control ignore writes, read zero.
// - Trigger info returns 0x8064 in bits 15:0, upper bits zero.
// - Trigger info returns 1 when the selected trigger does not exist.
// - Debug control bits 31:28 read 4.
// - Bit 15 set makes a machine-mode breakpoint enter debug mode.
// - Bit 2 enables single step; bit 11 allows interrupts while stepping.
// - Bits 8:6 report debug entry cause; bit 3 reports pending NMI.
// - Bits 1:0 read 3, bit 4 reads 1, timer-halt bit reads 0.
// - Trigger select chooses which trigger the shared addresses reach.
`ifndef DEBUG_TRIGGER_CFG_SVH
`define DEBUG_TRIGGER_CFG_SVH
`define ADDR_TRIG_SELECT   12'h7A0
`define ADDR_TRIG_CONFIG   12'h7A1
`define ADDR_TRIG_COMPARE  12'h7A2
`define ADDR_TRIG_EXTRA    12'h7A3
`define ADDR_TRIG_INFO     12'h7A4
`define ADDR_TRIG_CONTROL  12'h7A5
`define ADDR_DEBUG_CTRL    12'h7B0
`define NUM_TRIGGERS       32'h1
`define TYPE_EXCEPTION     4'h5
`define TYPE_MATCH6        4'h6
`define TYPE_DISABLED      4'hF
`define DISABLED_VALUE     32'hF800_0000
`define MATCH6_RESET_CTRL  7'h00
`define CMP_EQUAL          4'h0
`define CMP_AT_LEAST       4'h2
`define CMP_BELOW          4'h3
`define ACTION_DEBUG       4'h1
`define INFO_VALUE         32'h0000_8064
`define INFO_NO_TRIGGER    32'h0000_0001
`define EXT_DEBUG_VERSION  4'h4
`define PRIOR_PRIV_M       2'h3
`define EXC_SELECT_MASK    32'h0100_08AE
`define DCSR_RESET         32'h4000_0413
`endif

// [rtl/debug_trigger_csr_bank.sv]
// Purpose: Trigger and debug control CSR bank with address and exception matching
// Assumes: CSR requests and pipeline events come from logic on clk_sys
// Notes:   One trigger; read data and trigger request are registered
`timescale 1ns/1ps
`include "debug_trigger_cfg.svh"
module debug_trigger_csr_bank (
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire logic                         clk_en,
  input  wire debug_trigger_pkg::csr_req_t  csr_req,
  input  wire logic                         debug_mode,
  input  wire logic                         machine_mode,
  input  wire debug_trigger_pkg::pipe_event_t pipe_event,
  input  wire logic                         debug_entry,
  input  wire logic [2:0]                   debug_cause,
  input  wire logic                         nmi_pending,
  output logic [31:0]                       csr_rdata,
  output logic                              csr_ack,
  output logic                              csr_error,
  output logic                              trigger_hit,
  output logic                              step_enable,
  output logic                              step_irq_enable,
  output logic                              debug_on_break_m,
  output logic                              counter_halt_ctl
);
  import debug_trigger_pkg::*;

  // ----------------------------------------------------------------
  // Stored state
  // ----------------------------------------------------------------
  trig_kind_t  kind;
  logic        debug_only_write;
  logic [3:0]  cmp_mode;
  logic        machine_en;
  logic [2:0]  access_en;
  logic [31:0] trigger_compare_reg;
  logic [31:0] trig_select;
  logic [2:0]  cause;
  logic        nmi_sync;

  logic        wr;
  logic        sel_ok;
  logic        tdata_wr_ok;
  logic [31:0] wd;
  logic [31:0] cmp_view;
  logic [3:0]  next_cmp_mode;
  logic [31:0] cfg_view;
  logic [31:0] dcsr_view;
  logic [31:0] next_rdata;
  logic        next_err;

  assign wr     = csr_req.valid && csr_req.write;
  assign wd     = csr_req.wdata;
  // Exception view shows only the selectable cause bits, even after a type change
  assign cmp_view = (kind == TRIG_EXCEPTION) ? (trigger_compare_reg & `EXC_SELECT_MASK)
                                             : trigger_compare_reg;
  assign sel_ok = trig_select < `NUM_TRIGGERS;
  // Trigger data writes need debug mode while the mode bit is set
  assign tdata_wr_ok = sel_ok && (debug_mode || (!debug_only_write && machine_mode));

  always_comb begin
    case (wd[10:7])
      `CMP_EQUAL, `CMP_AT_LEAST, `CMP_BELOW: next_cmp_mode = wd[10:7];
      default: next_cmp_mode = `CMP_EQUAL;
    endcase
  end

  // ----------------------------------------------------------------
  // Trigger select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trig_select <= 32'h0;
    end else if (clk_en && wr && csr_req.addr == `ADDR_TRIG_SELECT) begin
      trig_select <= wd;
    end
  end

  // ----------------------------------------------------------------
  // First trigger data register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      kind             <= TRIG_DISABLED;
      debug_only_write <= 1'b1;
      cmp_mode         <= `CMP_EQUAL;
      machine_en       <= 1'b0;
      access_en        <= 3'h0;
    end else if (clk_en && wr && csr_req.addr == `ADDR_TRIG_CONFIG && tdata_wr_ok) begin
      debug_only_write <= 1'b1;
      if (wd == 32'h0) begin
        kind <= TRIG_DISABLED;
      end else begin
        case (wd[31:28])
          `TYPE_MATCH6: begin
            kind       <= TRIG_MATCH6;
            cmp_mode   <= next_cmp_mode;
            machine_en <= wd[6];
            access_en  <= wd[2:0];
          end
          `TYPE_EXCEPTION: begin
            kind       <= TRIG_EXCEPTION;
            machine_en <= wd[9];
          end
          default: kind <= TRIG_DISABLED;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Compare value / exception select
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trigger_compare_reg <= 32'h0;
    end else if (clk_en && wr && csr_req.addr == `ADDR_TRIG_COMPARE && tdata_wr_ok) begin
      if (kind == TRIG_EXCEPTION) begin
        trigger_compare_reg <= wd & `EXC_SELECT_MASK;
      end else begin
        trigger_compare_reg <= wd;
      end
    end
  end

  // ----------------------------------------------------------------
  // Debug control and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      debug_on_break_m <= 1'b0;
      step_irq_enable  <= 1'b0;
      counter_halt_ctl <= 1'b1;
      step_enable      <= 1'b0;
    end else if (clk_en && wr && csr_req.addr == `ADDR_DEBUG_CTRL && debug_mode) begin
      debug_on_break_m <= wd[15];
      step_irq_enable  <= wd[11];
      counter_halt_ctl <= wd[10];
      step_enable      <= wd[2];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cause <= 3'h0;
    end else if (clk_en && debug_entry) begin
      cause <= debug_cause;
    end
  end

  // NMI pending comes from the pipeline on this clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      nmi_sync <= 1'b0;
    end else if (clk_en) begin
      nmi_sync <= nmi_pending;
    end
  end

  // ----------------------------------------------------------------
  // Read views
  // ----------------------------------------------------------------
  always_comb begin
    cfg_view = `DISABLED_VALUE;
    case (kind)
      TRIG_MATCH6: begin
        cfg_view        = 32'h0;
        cfg_view[31:28] = `TYPE_MATCH6;
        cfg_view[27]    = 1'b1;
        cfg_view[15:12] = `ACTION_DEBUG;
        cfg_view[10:7]  = cmp_mode;
        cfg_view[6]     = machine_en;
        cfg_view[2:0]   = access_en;
      end
      TRIG_EXCEPTION: begin
        cfg_view        = 32'h0;
        cfg_view[31:28] = `TYPE_EXCEPTION;
        cfg_view[27]    = 1'b1;
        cfg_view[9]     = machine_en;
        cfg_view[5:0]   = 6'h01;
      end
      TRIG_DISABLED: cfg_view = `DISABLED_VALUE;
      default: cfg_view = `DISABLED_VALUE;
    endcase
  end

  always_comb begin
    dcsr_view        = 32'h0;
    dcsr_view[31:28] = `EXT_DEBUG_VERSION;
    dcsr_view[15]    = debug_on_break_m;
    dcsr_view[11]    = step_irq_enable;
    dcsr_view[10]    = counter_halt_ctl;
    dcsr_view[9]     = 1'b0;
    dcsr_view[8:6]   = cause;
    dcsr_view[4]     = 1'b1;
    dcsr_view[3]     = nmi_sync;
    dcsr_view[2]     = step_enable;
    dcsr_view[1:0]   = `PRIOR_PRIV_M;
  end

  always_comb begin
    next_rdata = 32'h0;
    next_err   = 1'b0;
    case (csr_req.addr)
      `ADDR_TRIG_SELECT:  next_rdata = trig_select;
      `ADDR_TRIG_CONFIG:  next_rdata = sel_ok ? cfg_view : 32'h0;
      `ADDR_TRIG_COMPARE: next_rdata = sel_ok ? cmp_view : 32'h0;
      `ADDR_TRIG_EXTRA:   next_rdata = 32'h0;
      `ADDR_TRIG_INFO:    next_rdata = sel_ok ? `INFO_VALUE : `INFO_NO_TRIGGER;
      `ADDR_TRIG_CONTROL: next_rdata = 32'h0;
      `ADDR_DEBUG_CTRL:   next_rdata = dcsr_view;
      default:            next_err   = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // CSR answer, registered
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      csr_rdata <= 32'h0;
      csr_ack   <= 1'b0;
      csr_error <= 1'b0;
    end else if (clk_en) begin
      csr_ack   <= csr_req.valid;
      csr_error <= csr_req.valid && next_err;
      csr_rdata <= csr_req.valid ? next_rdata : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // Matching
  // ----------------------------------------------------------------
  function automatic logic addr_cmp(input logic [3:0] mode, input logic [31:0] a,
                                    input logic [31:0] ref_val);
    case (mode)
      `CMP_AT_LEAST: addr_cmp = a >= ref_val;
      `CMP_BELOW:    addr_cmp = a < ref_val;
      default:       addr_cmp = a == ref_val;
    endcase
  endfunction : addr_cmp

  logic next_hit;
  always_comb begin
    next_hit = 1'b0;
    if (machine_mode && !debug_mode && machine_en) begin
      case (kind)
        TRIG_MATCH6: begin
          // Full address compare, any access width; request before execution
          next_hit = (access_en[2] && pipe_event.fetch_valid
                      && addr_cmp(cmp_mode, pipe_event.fetch_addr, trigger_compare_reg))
                  || (access_en[1] && pipe_event.store_valid
                      && addr_cmp(cmp_mode, pipe_event.data_addr, trigger_compare_reg))
                  || (access_en[0] && pipe_event.load_valid
                      && addr_cmp(cmp_mode, pipe_event.data_addr, trigger_compare_reg));
        end
        TRIG_EXCEPTION: begin
          next_hit = pipe_event.exc_valid && cmp_view[pipe_event.exc_code];
        end
        TRIG_DISABLED: next_hit = 1'b0;
        default: next_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      trigger_hit <= 1'b0;
    end else if (clk_en) begin
      trigger_hit <= next_hit;
    end
  end
endmodule : debug_trigger_csr_bank

// [rtl/debug_trigger_pkg.sv]
// Purpose: Types shared by the debug trigger register bank
// Assumes: Constants come from debug_trigger_cfg.svh
// Notes:   Packed carriers for the CSR port and pipeline match inputs
package debug_trigger_pkg;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } csr_req_t;

  typedef struct packed {
    logic        fetch_valid;
    logic [31:0] fetch_addr;
    logic        load_valid;
    logic        store_valid;
    logic [31:0] data_addr;
    logic        exc_valid;
    logic [4:0]  exc_code;
  } pipe_event_t;

  typedef enum logic [2:0] {
    TRIG_MATCH6    = 3'b001,
    TRIG_EXCEPTION = 3'b010,
    TRIG_DISABLED  = 3'b100
  } trig_kind_t;
endpackage : debug_trigger_pkg

// [tb/debug_trigger_csr_bank_props.sv]
// Purpose: Port checker for the debug trigger register bank
// Assumes: One clock domain, reset active low
// Notes:   Bound to the design top
`timescale 1ns/1ps
`include "debug_trigger_cfg.svh"
module debug_trigger_csr_bank_props
  import debug_trigger_pkg::*;
(
  input wire logic                           clk_sys,
  input wire logic                           rstn,
  input wire logic                           clk_en,
  input wire debug_trigger_pkg::csr_req_t    csr_req,
  input wire logic                           debug_mode,
  input wire debug_trigger_pkg::pipe_event_t pipe_event,
  input wire logic [31:0]                    csr_rdata,
  input wire logic                           csr_ack,
  input wire logic                           csr_error,
  input wire logic                           trigger_hit,
  input wire logic                           step_enable
);
  logic        take;
  logic        rd;
  logic        ev;
  logic [11:0] a;
  assign take = clk_en && csr_req.valid;
  assign rd   = take && !csr_req.write;
  assign a    = csr_req.addr;
  assign ev   = pipe_event.fetch_valid || pipe_event.load_valid || pipe_event.store_valid
                || pipe_event.exc_valid;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ------------------------------
  // Properties
  // ------------------------------
  a_ack_after_req: assert property (take |=> csr_ack)
    else $error("ack missing after request");
  a_no_stray_ack: assert property (!take |=> !csr_ack)
    else $error("ack without request");
  a_info_value: assert property (rd && a == `ADDR_TRIG_INFO |=>
    csr_rdata == 32'h0000_8064 || csr_rdata == 32'h0000_0001) else $error("bad info value");
  a_unused_zero: assert property (rd && (a == `ADDR_TRIG_EXTRA || a == `ADDR_TRIG_CONTROL)
    |=> csr_rdata == 32'h0) else $error("unused register not zero");
  a_dcsr_fixed: assert property (rd && a == `ADDR_DEBUG_CTRL |=>
    csr_rdata[31:28] == 4'h4 && csr_rdata[27:16] == 12'h0 && csr_rdata[14:12] == 3'h0
    && csr_rdata[9] == 1'b0 && csr_rdata[5:4] == 2'h1 && csr_rdata[1:0] == 2'h3)
    else $error("debug control fixed bits wrong");
  a_match_view: assert property (rd && a == `ADDR_TRIG_CONFIG |=>
    csr_rdata[31:28] != 4'h6 || (csr_rdata[27:11] == 17'h10002 && csr_rdata[5:3] == 3'h0))
    else $error("match view fixed bits wrong");
  a_disabled_view: assert property (rd && a == `ADDR_TRIG_CONFIG |=>
    csr_rdata[31:28] != 4'hF || csr_rdata == 32'hF800_0000) else $error("bad disabled view");
  a_hit_cause: assert property ($rose(trigger_hit) |-> $past(ev))
    else $error("hit without pipeline event");
  a_step_write: assert property ($rose(step_enable) |-> $past(take && csr_req.write &&
    a == `ADDR_DEBUG_CTRL && debug_mode)) else $error("step set without debug write");
  c_hit: cover property (trigger_hit);
  c_error: cover property (csr_ack && csr_error);
  c_step: cover property ($rose(step_enable));
endmodule : debug_trigger_csr_bank_props

bind debug_trigger_csr_bank debug_trigger_csr_bank_props u_props (
  .clk_sys     (clk_sys),
  .rstn        (rstn),
  .clk_en      (clk_en),
  .csr_req     (csr_req),
  .debug_mode  (debug_mode),
  .pipe_event  (pipe_event),
  .csr_rdata   (csr_rdata),
  .csr_ack     (csr_ack),
  .csr_error   (csr_error),
  .trigger_hit (trigger_hit),
  .step_enable (step_enable)
);

// [tb/debug_trigger_csr_bank_tb.sv]
// Purpose: Self-checking bench for the debug trigger register bank
// Assumes: CSR port answers exactly one cycle after a request
// Notes:   Pipeline traffic comes from pipe_model
`timescale 1ns/1ps
`include "debug_trigger_cfg.svh"
module debug_trigger_csr_bank_tb;
  import debug_trigger_pkg::*;
  logic        clk_sys, rstn, debug_mode, machine_mode, debug_entry, nmi_pending, err;
  logic        csr_ack, csr_error, trigger_hit, step_enable, step_irq_enable;
  logic        debug_on_break_m, counter_halt_ctl;
  logic [2:0]  debug_cause;
  logic [1:0]  kind_req;
  logic        exc_req;
  logic [31:0] addr_req, rd, csr_rdata;
  csr_req_t    csr_req;
  pipe_event_t pipe_event;
  int          fail_count, cmp_count;
  logic [31:0] cfg [3] = '{32'h6000_1044, 32'h6000_1141, 32'h6000_11C2};
  logic [31:0] hit_a [3] = '{32'h8000_1000, 32'h8000_1004, 32'h8000_0FFC};
  logic [31:0] miss_a [3] = '{32'h8000_1004, 32'h8000_0FFC, 32'h8000_1000};

  debug_trigger_csr_bank uut (.clk_sys(clk_sys), .rstn(rstn), .clk_en(1'b1),
    .csr_req(csr_req), .debug_mode(debug_mode), .machine_mode(machine_mode),
    .pipe_event(pipe_event), .debug_entry(debug_entry), .debug_cause(debug_cause),
    .nmi_pending(nmi_pending), .csr_rdata(csr_rdata), .csr_ack(csr_ack),
    .csr_error(csr_error), .trigger_hit(trigger_hit), .step_enable(step_enable),
    .step_irq_enable(step_irq_enable), .debug_on_break_m(debug_on_break_m),
    .counter_halt_ctl(counter_halt_ctl));
  pipe_model u_pipe (.clk_sys(clk_sys), .rstn(rstn), .kind_req(kind_req),
    .exc_req(exc_req), .addr_req(addr_req), .pipe_event(pipe_event));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic csr_op(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    csr_req <= '{1'b1, w, a, d};
    @(posedge clk_sys);
    csr_req.valid <= 1'b0;
    #1;
    chk({31'h0, csr_ack}, 32'h1);
    rd = csr_rdata;
    err = csr_error;
  endtask : csr_op
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    csr_op(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rd_chk
  task automatic fire(input logic [1:0] k, input logic [31:0] ad, input logic exp);
    logic seen;
    seen = 1'b0;
    @(posedge clk_sys);
    kind_req <= k;
    exc_req  <= (k == 2'h0);
    addr_req <= ad;
    @(posedge clk_sys);
    kind_req <= 2'h0;
    exc_req  <= 1'b0;
    repeat (3) begin
      @(posedge clk_sys);
      #1;
      seen = seen | trigger_hit;
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask : fire
  task automatic modes(input logic dm, input logic mm);
    @(posedge clk_sys);
    debug_mode   <= dm;
    machine_mode <= mm;
  endtask : modes
  task automatic final_report;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk_sys);
    fail_count++;
    final_report;
  end
  // ------------------------------
  // Tests
  // ------------------------------
  initial begin
    {rstn, debug_mode, debug_entry, nmi_pending, debug_cause, kind_req, exc_req} = '0;
    {csr_req, addr_req} = '0;
    machine_mode = 1'b1;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(`ADDR_TRIG_CONFIG, 32'hF800_0000);
    rd_chk(`ADDR_TRIG_COMPARE, 32'h0);
    rd_chk(`ADDR_TRIG_INFO, 32'h0000_8064);
    rd_chk(`ADDR_DEBUG_CTRL, 32'h4000_0413);
    chk({28'h0, step_enable, step_irq_enable, debug_on_break_m, counter_halt_ctl}, 32'h1);
    csr_op(1'b0, 12'h7B5, 32'h0);
    chk({31'h0, err}, 32'h1);
    csr_op(1'b1, `ADDR_TRIG_CONFIG, 32'h6800_1044);
    rd_chk(`ADDR_TRIG_CONFIG, 32'hF800_0000);
    csr_op(1'b1, `ADDR_TRIG_COMPARE, 32'h1234_5678);
    rd_chk(`ADDR_TRIG_COMPARE, 32'h0);
    csr_op(1'b1, `ADDR_DEBUG_CTRL, 32'h0);
    rd_chk(`ADDR_DEBUG_CTRL, 32'h4000_0413);
    modes(1'b1, 1'b1);
    csr_op(1'b1, `ADDR_TRIG_CONFIG, 32'h6000_1044);
    rd_chk(`ADDR_TRIG_CONFIG, 32'h6800_1044);
    csr_op(1'b1, `ADDR_TRIG_CONFIG, 32'h6FFF_FFFF);
    rd_chk(`ADDR_TRIG_CONFIG, 32'h6800_1047);
    csr_op(1'b1, `ADDR_TRIG_CONFIG, 32'h0);
    rd_chk(`ADDR_TRIG_CONFIG, 32'hF800_0000);
    csr_op(1'b1, `ADDR_TRIG_EXTRA, 32'hFFFF_FFFF);
    csr_op(1'b1, `ADDR_TRIG_CONTROL, 32'hFFFF_FFFF);
    rd_chk(`ADDR_TRIG_EXTRA, 32'h0);
    rd_chk(`ADDR_TRIG_CONTROL, 32'h0);
    csr_op(1'b1, `ADDR_TRIG_COMPARE, 32'h8000_1000);
    rd_chk(`ADDR_TRIG_COMPARE, 32'h8000_1000);
    for (int i = 0; i < 3; i++) begin
      modes(1'b1, 1'b1);
      csr_op(1'b1, `ADDR_TRIG_CONFIG, cfg[i]);
      modes(1'b0, 1'b1);
      fire(2'(i + 1), hit_a[i], 1'b1);
      fire(2'(i + 1), miss_a[i], 1'b0);
    end
    modes(1'b0, 1'b0);
    fire(2'h3, 32'h8000_0FFC, 1'b0);
    modes(1'b1, 1'b1);
    csr_op(1'b1, `ADDR_TRIG_CONFIG, 32'h6000_1004);
    modes(1'b0, 1'b1);
    fire(2'h1, 32'h8000_1000, 1'b0);
    modes(1'b1, 1'b1);
    csr_op(1'b1, `ADDR_TRIG_CONFIG, 32'h5000_0201);
    rd_chk(`ADDR_TRIG_CONFIG, 32'h5800_0201);
    rd_chk(`ADDR_TRIG_COMPARE, 32'h0);
    csr_op(1'b1, `ADDR_TRIG_COMPARE, 32'hFFFF_FFFF);
    rd_chk(`ADDR_TRIG_COMPARE, 32'h0100_08AE);
    modes(1'b0, 1'b1);
    fire(2'h0, 32'h3, 1'b1);
    fire(2'h0, 32'hB, 1'b1);
    fire(2'h0, 32'h4, 1'b0);
    modes(1'b1, 1'b1);
    csr_op(1'b1, `ADDR_TRIG_SELECT, 32'h1);
    rd_chk(`ADDR_TRIG_INFO, 32'h1);
    rd_chk(`ADDR_TRIG_CONFIG, 32'h0);
    csr_op(1'b1, `ADDR_TRIG_SELECT, 32'h0);
    rd_chk(`ADDR_TRIG_INFO, 32'h0000_8064);
    csr_op(1'b1, `ADDR_DEBUG_CTRL, 32'hFFFF_FFFF);
    rd_chk(`ADDR_DEBUG_CTRL, 32'h4000_8C17);
    chk({28'h0, step_enable, step_irq_enable, debug_on_break_m, counter_halt_ctl}, 32'hF);
    @(posedge clk_sys);
    debug_entry <= 1'b1;
    debug_cause <= 3'h3;
    nmi_pending <= 1'b1;
    @(posedge clk_sys);
    debug_entry <= 1'b0;
    rd_chk(`ADDR_DEBUG_CTRL, 32'h4000_8CDF);
    final_report;
  end
endmodule : debug_trigger_csr_bank_tb

// [tb/pipe_model.sv]
// Purpose: Pipeline model presenting fetch, load and store addresses
// Assumes: Requests come from the bench one cycle ahead
// Notes:   Address lines not in use show the inverse of their last value
`timescale 1ns/1ps
module pipe_model
  import debug_trigger_pkg::*;
(
  input  wire logic                         clk_sys,
  input  wire logic                         rstn,
  input  wire logic [1:0]                   kind_req,
  input  wire logic                         exc_req,
  input  wire logic [31:0]                  addr_req,
  output debug_trigger_pkg::pipe_event_t    pipe_event
);
  // Kind 1 fetch, 2 load, 3 store; exception code from addr_req[4:0]
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pipe_event <= '0;
    end else begin
      pipe_event.fetch_valid <= (kind_req == 2'h1);
      pipe_event.load_valid  <= (kind_req == 2'h2);
      pipe_event.store_valid <= (kind_req == 2'h3);
      pipe_event.fetch_addr  <= (kind_req == 2'h1) ? addr_req : ~pipe_event.fetch_addr;
      pipe_event.data_addr   <= kind_req[1] ? addr_req : ~pipe_event.data_addr;
      pipe_event.exc_valid   <= exc_req;
      pipe_event.exc_code    <= exc_req ? addr_req[4:0] : ~pipe_event.exc_code;
    end
  end
endmodule : pipe_model
